// >>> hdl/char_display_pkg.sv
// Purpose: shared constants for the character display host port
// Assumes: 7-bit address pointer, 128-byte text RAM, 64-byte user glyph RAM
// Notes:   instruction encodings not given elsewhere are chosen plainly here
package char_display_pkg;
  localparam int          data_width          = 8;
  localparam int          addr_width          = 7;
  localparam int          text_depth          = 128;
  localparam int          glyph_depth         = 64;
  localparam int          line_span           = 64;
  localparam int          stage_count         = 100;
  localparam int          busy_bit            = 7;
  // instruction field positions
  localparam int          text_addr_bit       = 7;   // 1xxxxxxx sets text RAM address
  localparam int          glyph_addr_bit      = 6;   // 01xxxxxx sets glyph RAM address
  localparam int          func_set_bit        = 5;   // 001xxxxx function set
  localparam int          func_lines_bit      = 3;
  localparam int          func_font_lsb       = 0;   // font table select, 2 bits
  localparam int          shift_cmd_bit       = 4;   // 0001xxxx display shift
  localparam int          shift_right_bit     = 2;
  localparam int          entry_cmd_bit       = 2;   // 000001xx entry mode
  localparam int          entry_incr_bit      = 1;
  // reset values
  localparam logic [1:0]  font_reset          = 2'h1; // english/japanese table
  localparam logic        lines_reset         = 1'b0;
  localparam logic        incr_reset          = 1'b1;
  // timing: internal operation time
  localparam int          op_time_ns          = 400;
  localparam int          clock_period_ns     = 100;
  localparam int          op_cycles           = (op_time_ns + clock_period_ns - 1) / clock_period_ns;
  typedef enum logic [1:0] {font_western_type, font_eng_jpn_type, font_eng_rus_type} font_type;
endpackage : char_display_pkg

// >>> hdl/cascade_shifter.sv
// Purpose: bidirectional serial shift register for the master/slave cascade
// Assumes: shift strobe already synchronised; shifts on its falling edge
// Notes:   direction select high moves data from the top stage toward stage one
`timescale 1ns/1ps
module cascade_shifter #(
  parameter int stage_count = 100
) (
  input  wire logic                   clock,
  input  wire logic                   reset,
  input  wire logic                   shift_fall,
  input  wire logic                   shift_direction_select,
  input  wire logic                   serial_in,
  output logic                        serial_out,
  output logic [stage_count-1:0]      stages
);
  logic [stage_count-1:0] stages_q;
  logic [stage_count-1:0] stages_d;

  // a single stage cannot shift in two directions
  if (stage_count < 2)
  begin : stage_count_check
    $error("stage_count too small");
  end

  // next shift value
  always_comb
  begin
    stages_d = stages_q;
    if (shift_fall)
    begin
      if (shift_direction_select)
        stages_d = {serial_in, stages_q[stage_count-1:1]}; // [RULE19]
      else
        stages_d = {stages_q[stage_count-2:0], serial_in}; // [RULE19]
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      stages_q <= '0;
    else
      stages_q <= stages_d;
  end

  assign stages     = stages_q;
  assign serial_out = shift_direction_select ? stages_q[0] : stages_q[stage_count-1];
endmodule : cascade_shifter

// >>> hdl/char_display_host_port.sv
// Purpose: host-facing register port of a character display controller
// Assumes: host strobes are synchronous to clock; one access per enable pulse
// Notes:   cascade pins are three-signal; master drives them, slave receives
//
// Overview of operation
// (RULE1) two 8-bit registers, instruction and data, over an 8-bit bus
// (RULE2) register select low picks instruction, high picks data
// (RULE3) select low, write: byte taken as instruction and executed
// (RULE4) select low, read: busy on bit 7, pointer on bits 6..0
// (RULE5) select high, write: byte latched then stored at the pointer
// (RULE6) select high, read: data register loaded from RAM at the pointer
// (RULE7) instruction register is write only; status read replaces it
// (RULE8) busy reads 1 during internal work; instructions then ignored
// (RULE9) busy clears to 0 when work ends; next instruction accepted
// (RULE10) address instruction loads pointer and chooses text or glyph RAM
// (RULE11) each data access steps pointer by one, up or down
// (RULE12) text RAM holds 128 codes addressed by pointer bits 6..0
// (RULE13) one-line mode shows addresses 00..7F in order from position one
// (RULE14) two-line mode: line one 00..3F, line two 40..7F
// (RULE15) display shift moves shown address by one, wrapping per line
// (RULE16) master extends to 40 by 2 with a cascaded slave
// (RULE17) master/slave select sets direction of data, shift and hold strobes
// (RULE18) slave shifts serial data on falling shift strobe edge
// (RULE19) 100-stage register shifts by the shift direction select
// (RULE20) glyph ROM has three font tables, english/japanese by default
// (RULE21) host drives read/write high to read, low to write
// (RULE22) host polls busy until 0 before the next access
`timescale 1ns/1ps
module char_display_host_port #(
  parameter int op_cycles = char_display_pkg::op_cycles
) (
  input  wire logic                                   clock,
  input  wire logic                                   reset,
  input  wire logic                                   enable,
  input  wire logic                                   register_select,
  input  wire logic                                   read_write_select,
  input  wire logic [char_display_pkg::data_width-1:0] bus_in,
  output logic      [char_display_pkg::data_width-1:0] bus_out,
  output logic                                        bus_oe,
  input  wire logic                                   master_select,
  input  wire logic                                   shift_direction_select,
  input  wire logic                                   serial_in,
  output logic                                        serial_out,
  output logic                                        serial_oe,
  input  wire logic                                   shift_strobe_in,
  output logic                                        shift_strobe_out,
  output logic                                        shift_strobe_oe,
  input  wire logic                                   hold_strobe_in,
  output logic                                        hold_strobe_out,
  output logic                                        hold_strobe_oe,
  input  wire logic [6:0]                             scan_position,
  input  wire logic                                   scan_line,
  output logic      [char_display_pkg::addr_width-1:0] scan_address,
  output logic      [char_display_pkg::data_width-1:0] scan_code,
  output logic                                        two_line_mode,
  output logic      [1:0]                             font_table,
  output logic                                        hold_pulse
);
  localparam int aw = char_display_pkg::addr_width;
  localparam int dw = char_display_pkg::data_width;

  // refuse a busy span that the 8-bit counter cannot hold
  if (op_cycles < 1 || op_cycles > 256)
  begin : op_cycles_check
    $error("op_cycles must lie between 1 and 256");
  end

  typedef enum logic [1:0] {idle_type, store_type, fetch_type, work_type} phase_type;

  // memories: text RAM and user glyph RAM
  logic [dw-1:0] text_ram  [char_display_pkg::text_depth];   // [RULE12]
  logic [dw-1:0] glyph_ram [char_display_pkg::glyph_depth];

  phase_type     phase_q, phase_d;
  logic [7:0]    count_q, count_d;
  logic [dw-1:0] instr_q, instr_d;          // instruction register
  logic [dw-1:0] data_holding_q, data_holding_d;
  logic [aw-1:0] pointer_q, pointer_d;
  logic          glyph_sel_q, glyph_sel_d;
  logic          incr_q, incr_d;
  logic          lines_q, lines_d;
  logic [1:0]    font_q, font_d;
  logic [aw-1:0] shift_q, shift_d;
  logic [dw-1:0] bus_q, bus_d;
  logic          busy_indicator;
  logic          ram_write;
  logic [aw-1:0] step_pointer;
  logic [2:0]    strobe_sync_q, hold_sync_q;
  logic [1:0]    serial_sync_q;
  logic          shift_fall;
  logic [2:0]    div_q;
  logic          cascade_data;

  assign busy_indicator = (phase_q != idle_type);             // [RULE8] [RULE9]
  assign step_pointer   = incr_q ? pointer_q + 7'h01 : pointer_q - 7'h01; // [RULE11]

  // access decode and internal operation sequence
  always_comb
  begin
    phase_d        = phase_q;
    count_d        = count_q;
    instr_d        = instr_q;
    data_holding_d = data_holding_q;
    pointer_d      = pointer_q;
    glyph_sel_d    = glyph_sel_q;
    incr_d         = incr_q;
    lines_d        = lines_q;
    font_d         = font_q;
    shift_d        = shift_q;
    bus_d          = bus_q;
    ram_write      = 1'b0;
    // status reads are answered in every phase so the host can poll busy
    if (enable && !register_select && read_write_select)
      bus_d = {busy_indicator, pointer_q};                      // [RULE4] [RULE7] [RULE8]
    unique case (phase_q)
      idle_type:
      begin
        if (enable && register_select && read_write_select)
          bus_d = data_holding_q;                               // [RULE6]
        if (enable && !register_select && !read_write_select)
        begin
          instr_d = bus_in;                                     // [RULE1] [RULE2] [RULE3]
          phase_d = work_type;
          count_d = 8'(op_cycles - 1);
        end
        else if (enable && register_select && !read_write_select)
        begin
          data_holding_d = bus_in;                              // [RULE5]
          phase_d        = store_type;
        end
        else if (enable && register_select && read_write_select)
          phase_d = fetch_type;
      end
      store_type:
      begin
        ram_write = 1'b1;                                       // [RULE5]
        pointer_d = step_pointer;                               // [RULE11]
        phase_d   = idle_type;
      end
      fetch_type:
      begin
        data_holding_d = glyph_sel_q ? glyph_ram[pointer_q[5:0]] : text_ram[pointer_q]; // [RULE6]
        pointer_d      = step_pointer;                          // [RULE11]
        phase_d        = idle_type;
      end
      work_type:
      begin
        if (count_q == 8'h00)
        begin
          phase_d = idle_type;                                  // [RULE9]
          if (instr_q[char_display_pkg::text_addr_bit])
          begin
            pointer_d   = instr_q[aw-1:0];                      // [RULE10]
            glyph_sel_d = 1'b0;
          end
          else if (instr_q[char_display_pkg::glyph_addr_bit])
          begin
            pointer_d   = {1'b0, instr_q[5:0]};                 // [RULE10]
            glyph_sel_d = 1'b1;
          end
          else if (instr_q[char_display_pkg::func_set_bit])
          begin
            lines_d = instr_q[char_display_pkg::func_lines_bit];
            if (instr_q[1:0] != 2'h3)
              font_d = instr_q[1:0];                            // [RULE20]
          end
          else if (instr_q[char_display_pkg::shift_cmd_bit])
          begin
            if (instr_q[char_display_pkg::shift_right_bit])
              shift_d = shift_q - 7'h01;                        // [RULE15]
            else
              shift_d = shift_q + 7'h01;                        // [RULE15]
          end
          else if (instr_q[char_display_pkg::entry_cmd_bit])
            incr_d = instr_q[char_display_pkg::entry_incr_bit];
        end
        else
          count_d = count_q - 8'h01;                            // [RULE8] new writes ignored here
      end
      default: phase_d = idle_type;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      phase_q        <= idle_type;
      count_q        <= 8'h00;
      instr_q        <= 8'h00;
      data_holding_q <= 8'h00;
      pointer_q      <= 7'h00;
      glyph_sel_q    <= 1'b0;
      incr_q         <= char_display_pkg::incr_reset;
      lines_q        <= char_display_pkg::lines_reset;
      font_q         <= char_display_pkg::font_reset;      // [RULE20]
      shift_q        <= 7'h00;
      bus_q          <= 8'h00;
    end
    else
    begin
      phase_q        <= phase_d;
      count_q        <= count_d;
      instr_q        <= instr_d;
      data_holding_q <= data_holding_d;
      pointer_q      <= pointer_d;
      glyph_sel_q    <= glyph_sel_d;
      incr_q         <= incr_d;
      lines_q        <= lines_d;
      font_q         <= font_d;
      shift_q        <= shift_d;
      bus_q          <= bus_d;
    end
  end

  // memory writes, no reset on storage
  always_ff @(posedge clock)
  begin
    if (ram_write && glyph_sel_q)
      glyph_ram[pointer_q[5:0]] <= data_holding_q;
    else if (ram_write)
      text_ram[pointer_q] <= data_holding_q;                    // [RULE5]
  end

  assign bus_out = bus_q;
  assign bus_oe  = enable && read_write_select;

  // display position to text RAM address, with shift and per-line wrap
  always_comb
  begin
    scan_address = 7'h00;
    if (lines_q)
      scan_address = {scan_line, 6'(scan_position[5:0] + shift_q[5:0])}; // [RULE14] [RULE15]
    else
      scan_address = 7'(scan_position + shift_q);               // [RULE13] [RULE15]
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      scan_code <= 8'h00;
    else
      scan_code <= text_ram[scan_address];
  end

  assign two_line_mode = lines_q;
  assign font_table    = font_q;

  // cascade strobe: synchronised input for slave, divided output for master
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      strobe_sync_q <= 3'h0;
      hold_sync_q   <= 3'h0;
      serial_sync_q <= 2'h0;
      div_q         <= 3'h0;
    end
    else
    begin
      strobe_sync_q <= {strobe_sync_q[1:0], shift_strobe_in};
      hold_sync_q   <= {hold_sync_q[1:0], hold_strobe_in};
      serial_sync_q <= {serial_sync_q[0], serial_in};
      div_q         <= div_q + 3'h1;
    end
  end

  // slave shifts on falling input strobe, master on its own divided strobe
  assign shift_fall = master_select ? (div_q == 3'h7)
                                    : (strobe_sync_q[2] && !strobe_sync_q[1]); // [RULE18]
  assign hold_pulse = master_select ? (div_q == 3'h7 && pointer_q == 7'h00)
                                    : (!hold_sync_q[2] && hold_sync_q[1]);

  cascade_shifter #(
    .stage_count (char_display_pkg::stage_count)
  ) u_shifter (
    .clock                  (clock),
    .reset                  (reset),
    .shift_fall             (shift_fall),
    .shift_direction_select (shift_direction_select),
    .serial_in              (master_select ? scan_code[0] : serial_sync_q[1]), // slave data aged like the strobe
    .serial_out             (cascade_data),
    .stages                 ()
  );

  // master drives all three cascade lines, slave receives them  [RULE16]
  assign serial_out       = cascade_data;
  assign shift_strobe_out = div_q[2];
  assign hold_strobe_out  = hold_pulse;
  assign serial_oe        = master_select;                      // [RULE17]
  assign shift_strobe_oe  = master_select;                      // [RULE17]
  assign hold_strobe_oe   = master_select;                      // [RULE17]
endmodule : char_display_host_port

// >>> testbench/char_display_host_port_sva.sv
// Purpose: assertions on the pins of the character display host port
// Assumes: busy span rebuilt from accepted accesses using the hand-over timing
// Notes:   font, line and address expectations are captured when accepted
`timescale 1ns/1ps
module char_display_host_port_sva #(
  parameter int op_cycles = char_display_pkg::op_cycles
) (
  input wire logic       clock,
  input wire logic       reset,
  input wire logic       enable,
  input wire logic       register_select,
  input wire logic       read_write_select,
  input wire logic [7:0] bus_in,
  input wire logic [7:0] bus_out,
  input wire logic       bus_oe,
  input wire logic       master_select,
  input wire logic       serial_oe,
  input wire logic       shift_strobe_oe,
  input wire logic       hold_strobe_oe,
  input wire logic       scan_line,
  input wire logic [6:0] scan_address,
  input wire logic       two_line_mode,
  input wire logic [1:0] font_table
);
  localparam int max_wait = 8;
  logic [3:0] busy_q, busy_d;
  logic [2:0] want_q, want_d;
  logic [6:0] addr_q, addr_d;
  logic       fresh_q, fresh_d;
  logic       take, iw, fs;
  // accepted accesses and instruction kinds
  assign take = enable && (busy_q == 4'h0);
  assign iw   = take && !register_select && !read_write_select;
  assign fs   = iw && bus_in[7:5] == 3'h1 && bus_in[1:0] != 2'h3;
  // next busy span, wanted font and lines, last text address set
  always_comb
  begin
    busy_d  = (busy_q != 4'h0) ? busy_q - 4'h1 : busy_q;
    want_d  = fs ? {bus_in[3], bus_in[1:0]} : want_q;
    addr_d  = (iw && bus_in[7]) ? bus_in[6:0] : addr_q;
    fresh_d = (iw && bus_in[7]) ? 1'b1 : ((take && register_select) || iw) ? 1'b0 : fresh_q;
    if (take && register_select)
      busy_d = 4'h1;
    else if (iw)
      busy_d = 4'(op_cycles);
  end
  // register the helper state
  always_ff @(posedge clock)
  begin
    busy_q  <= reset ? 4'h0 : busy_d;
    want_q  <= reset ? {char_display_pkg::lines_reset, char_display_pkg::font_reset} : want_d;
    addr_q  <= reset ? 7'h00 : addr_d;
    fresh_q <= reset ? 1'b0 : fresh_d;
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  cascade_dir_a: assert property (
    serial_oe == master_select && shift_strobe_oe == master_select && hold_strobe_oe == master_select)
    else $error("cascade enables do not follow master select");
  bus_drive_a: assert property (bus_oe == (enable && read_write_select))
    else $error("bus enable not tied to read strobe");
  read_hold_a: assert property (!(enable && read_write_select && (take || !register_select)) |=> $stable(bus_out))
    else $error("read byte moved without an accepted read");
  status_idle_a: assert property (take && !register_select && read_write_select |=> !bus_out[7])
    else $error("busy bit set on an accepted status read");
  busy_read_a: assert property (enable && !register_select && read_write_select && busy_q != 4'h0 |=> bus_out[7])
    else $error("busy bit clear on a status read while busy");
  font_reset_a: assert property ($fell(reset) |-> font_table == 2'h1 && !two_line_mode)
    else $error("font or line setting wrong after reset");
  font_set_a: assert property (
    fs |-> ##[1:max_wait] {two_line_mode, font_table} == want_q)
    else $error("function set not applied");
  two_line_map_a: assert property (two_line_mode |-> scan_address[6] == scan_line)
    else $error("line half of scan address wrong");
  addr_load_a: assert property (
    take && !register_select && read_write_select && fresh_q |=> bus_out[6:0] == addr_q)
    else $error("pointer not loaded by address instruction");
endmodule : char_display_host_port_sva

// >>> testbench/host_model.sv
// Purpose: host processor model driving the parallel register port
// Assumes: fixed waits cover the whole busy span, standing in for busy polling
// Notes:   bus_in carries the inverse of the last byte between accesses
`timescale 1ns/1ps
module host_model #(
  parameter int op_cycles = 4
) (
  input  wire logic  clock,
  output logic       enable,
  output logic       register_select,
  output logic       read_write_select,
  output logic [7:0] bus_in
);
  // idle levels at time zero
  initial
  begin
    enable = 1'b0;
    register_select = 1'b0;
    read_write_select = 1'b1;
    bus_in = 8'h00;
  end
  // one strobe per access, then wait out the busy span
  task automatic access(input logic rs, input logic rw, input logic [7:0] data, input bit wait_out);
    @(posedge clock);
    enable            <= 1'b1;
    register_select   <= rs;
    read_write_select <= rw;
    bus_in            <= data;
    @(posedge clock);
    enable <= 1'b0;
    bus_in <= ~data;
    if (wait_out)
      repeat ((!rs && !rw) ? op_cycles + 1 : 1) @(posedge clock);
  endtask : access
endmodule : host_model

// >>> testbench/tb.sv
// Purpose: self-checking bench for the character display host port
// Assumes: read answers arrive one edge after the strobe
// Notes:   reads queue their expected byte; a monitor compares at the falling edge
`timescale 1ns/1ps
module tb;
  localparam int op_cycles = 4;
  logic       clock, reset, enable, register_select, read_write_select, bus_oe, master_select, rd_pend, two;
  logic       shift_direction_select, serial_in, serial_out, serial_oe, shift_strobe_in, shift_strobe_out;
  logic       shift_strobe_oe, hold_strobe_in, hold_strobe_out, hold_strobe_oe, scan_line, two_line_mode, hold_pulse;
  logic [7:0] bus_in, bus_out, scan_code;
  logic [6:0] scan_position, scan_address, off;
  logic [1:0] font_table;
  logic [8:0] notes[$], note;
  logic [7:0] mem[4];
  logic [7:0] steps[6] = '{8'h14, 8'h10, 8'h10, 8'h21, 8'h14, 8'h14};
  int         bad_count = 0, check_count = 0;
  char_display_host_port #(.op_cycles(op_cycles)) u_char_display_host_port (.clock(clock), .reset(reset),
    .enable(enable), .register_select(register_select), .read_write_select(read_write_select), .bus_in(bus_in),
    .bus_out(bus_out), .bus_oe(bus_oe), .master_select(master_select), .shift_direction_select(shift_direction_select),
    .serial_in(serial_in), .serial_out(serial_out), .serial_oe(serial_oe), .shift_strobe_in(shift_strobe_in),
    .shift_strobe_out(shift_strobe_out), .shift_strobe_oe(shift_strobe_oe), .hold_strobe_in(hold_strobe_in),
    .hold_strobe_out(hold_strobe_out), .hold_strobe_oe(hold_strobe_oe), .scan_position(scan_position),
    .scan_line(scan_line), .scan_address(scan_address), .scan_code(scan_code), .two_line_mode(two_line_mode),
    .font_table(font_table), .hold_pulse(hold_pulse));
  host_model #(.op_cycles(op_cycles)) u_host_model (.clock(clock), .enable(enable),
    .register_select(register_select), .read_write_select(read_write_select), .bus_in(bus_in));
  // clock at 100 ns
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %0t %s: got %h want %h", $time, what, got, exp);
    end
  endtask : check
  task automatic rd(input logic rs, input logic [8:0] exp);
    notes.push_back(exp);
    u_host_model.access(rs, 1'b1, 8'h00, 1'b1);
  endtask : rd
  task automatic wr(input logic rs, input logic [7:0] data);
    u_host_model.access(rs, 1'b0, data, 1'b1);
  endtask : wr
  task automatic scan(input logic [6:0] pos, input logic line);
    logic [6:0] exp;
    exp = two ? {line, 6'(pos + off)} : 7'(pos + off);
    @(posedge clock);
    scan_position <= pos;
    scan_line     <= line;
    @(negedge clock);
    check({1'b0, scan_address}, {1'b0, exp}, "scan address");
  endtask : scan
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : conclude
  // read monitor: oldest note against the settled read byte
  always @(posedge clock)
    rd_pend <= enable && read_write_select;
  always @(negedge clock)
    if (rd_pend === 1'b1)
    begin
      note = notes.pop_front();
      if (note[8])
        check(bus_out, note[7:0], "read byte");
    end
  // watchdog
  initial
  begin
    repeat (5000) @(posedge clock);
    bad_count++;
    conclude();
  end
  // main sequence
  initial
  begin
    {reset, master_select, two} = 3'b111;
    {shift_direction_select, serial_in, shift_strobe_in, hold_strobe_in, scan_line} = 5'h00;
    scan_position = 7'h00;
    off = 7'h00;
    void'($urandom(32'hf84331a8));
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    rd(1'b0, 9'h100);
    check({6'h0, font_table}, 8'h01, "font after reset");
    check({7'h0, two_line_mode}, 8'h00, "lines after reset");
    $display("test reset done");
    wr(1'b0, 8'h85);
    rd(1'b0, 9'h105);
    foreach (mem[i])
    begin
      mem[i] = 8'($urandom);
      wr(1'b1, mem[i]);
    end
    rd(1'b0, 9'h109);
    wr(1'b0, 8'h85);
    rd(1'b1, 9'h000);
    foreach (mem[i])
      rd(1'b1, {1'b1, mem[i]});
    rd(1'b0, 9'h10a);
    wr(1'b0, 8'h04);
    wr(1'b0, 8'h90);
    wr(1'b1, 8'h3c);
    rd(1'b0, 9'h10f);
    wr(1'b0, 8'h06);
    $display("test data path done");
    u_host_model.access(1'b0, 1'b0, 8'h85, 1'b0);
    u_host_model.access(1'b0, 1'b0, 8'ha0, 1'b0);
    rd(1'b0, 9'h18f);
    rd(1'b0, 9'h105);
    $display("test busy done");
    for (int f = 0; f < 6; f++)
    begin
      wr(1'b0, 8'h20 | 8'(f % 3) | (8'(f / 3) << 3));
      check({6'h0, font_table}, 8'(f % 3), "font table");
      check({7'h0, two_line_mode}, 8'(f / 3), "line mode");
    end
    wr(1'b0, 8'h2b);
    check({6'h0, font_table}, 8'h02, "font code three ignored");
    $display("test function set done");
    for (int s = 0; s < 7; s++)
    begin
      scan(7'(two ? $urandom % 64 : $urandom % 128), 1'($urandom));
      scan(7'h00, 1'b1);
      if (s < 6)
      begin
        wr(1'b0, steps[s]);
        if (steps[s][4])
          off = steps[s][2] ? off - 7'h01 : off + 7'h01;
        else
          two = steps[s][3];
      end
    end
    scan(7'h11, 1'b0);
    @(negedge clock);
    check(scan_code, 8'h3c, "scan code");
    $display("test mapping done");
    for (int m = 1; m >= 0; m--)
    begin
      @(posedge clock);
      master_select          <= 1'(m);
      shift_direction_select <= 1'($urandom);
      repeat (16) @(posedge clock)
        {shift_strobe_in, serial_in, hold_strobe_in} <= {~shift_strobe_in, 1'($urandom), 1'b0};
      @(negedge clock);
      check({5'h0, serial_oe, shift_strobe_oe, hold_strobe_oe}, {5'h0, {3{1'(m)}}}, "cascade enables");
    end
    $display("test cascade done");
    conclude();
  end
endmodule : tb
bind char_display_host_port char_display_host_port_sva #(.op_cycles(op_cycles)) u_char_display_host_port_sva (
  .clock(clock), .reset(reset), .enable(enable), .register_select(register_select),
  .read_write_select(read_write_select), .bus_in(bus_in), .bus_out(bus_out), .bus_oe(bus_oe),
  .master_select(master_select), .serial_oe(serial_oe), .shift_strobe_oe(shift_strobe_oe),
  .hold_strobe_oe(hold_strobe_oe), .scan_line(scan_line), .scan_address(scan_address),
  .two_line_mode(two_line_mode), .font_table(font_table));
